// ===== dv/pcc_assertions.sv
// Checker: port-level assertions for the core clock control block
`timescale 1ns/1ps
module pcc_assertions
   import pcc_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        external_access_pin_i,
   input wire logic        pll_tracking_i,
   input wire logic        power_down_i,
   input wire logic        irq_in_service_i,
   input wire logic        osc_enable_o,
   input wire logic        tic_run_o,
   input wire logic        core_clk_en_o,
   input wire logic [2:0]  core_div_cur_o
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence bad_rd_s; psel_i && !penable_i && !pwrite_i && (paddr_i != 12'h000); endsequence
   sequence mid_period_s;
      (core_clk_en_o && core_div_cur_o != 3'h0 && !irq_in_service_i)
      ##1 ($stable(core_div_cur_o) && !irq_in_service_i);
   endsequence
   ready_high_a: assert property (pready_o) else $error("pready low");
   err_flag_a: assert property (psel_i && penable_i |-> pslverr_o == (paddr_i != 12'h000))
      else $error("pslverr wrong");
   unmapped_read_a: assert property (bad_rd_s |=> prdata_o == 32'h0) else $error("bad rdata");
   upper_zero_a: assert property (prdata_o[31:8] == 24'h0) else $error("upper rdata set");
   osc_fall_a: assert property ($fell(osc_enable_o) |-> $past(power_down_i))
      else $error("osc stopped awake");
   osc_run_a: assert property (!power_down_i |=> osc_enable_o) else $error("osc off");
   tic_follow_a: assert property (tic_run_o == osc_enable_o) else $error("tic mismatch");
   pulse_gap_a: assert property (mid_period_s |-> !core_clk_en_o) else $error("runt");
   reset_vals_a: assert property (disable iff (1'b0) rst_i |->
      core_div_cur_o == PCC_DIV_DEFAULT && osc_enable_o && !core_clk_en_o)
      else $error("reset values");
endmodule
bind pcc_top pcc_assertions chk_u (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .external_access_pin_i, .pll_tracking_i,
   .power_down_i, .irq_in_service_i, .osc_enable_o, .tic_run_o, .core_clk_en_o, .core_div_cur_o);

// ===== dv/tb.sv
// Testbench: APB-driven scenarios for the core clock control block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; \
   $display("unexpected %s exp %h got %h", nm, e, s); end end
module tb;
   import pcc_pkg::*;
   logic        mclk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, q;
   logic        external_access_pin_i, pll_tracking_i, power_down_i, irq_in_service_i;
   logic        osc_enable_o, tic_run_o, core_clk_en_o, e;
   logic [2:0]  core_div_cur_o;
   int          errors, tests_run, g;
   pcc_top dut_u (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .external_access_pin_i, .pll_tracking_i,
      .power_down_i, .irq_in_service_i, .osc_enable_o, .tic_run_o, .core_clk_en_o,
      .core_div_cur_o);
   // ------------------------------------------------------------
   // Bus and measurement tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_i);
      psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin @(posedge mclk_i); n++; end while (pready_o !== 1'b1 && n < 50);
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
      if (n >= 50) begin errors++; report_and_stop(); end
   endtask
   // Third gap is measured so a period begun under the old code is ignored
   task automatic gap2();
      int k;
      for (k = 0; k < 3; k++) begin
         g = 0;
         do begin @(posedge mclk_i); #1; g++; end while (core_clk_en_o !== 1'b1 && g < 300);
         if (g >= 300) begin errors++; report_and_stop(); end
      end
   endtask
   task automatic wt(input int n); repeat (n) @(posedge mclk_i); endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reg();
      apb(0, 12'h000, 0); `CHK("ctrl reset", 32'h03, q)
      `CHK("div reset", 3'h3, core_div_cur_o)
      // Every writable bit set, but the reserved bit kept at zero
      apb(1, 12'h000, 32'hdf);
      apb(0, 12'h000, 0);
      `CHK("ro bits", 32'h8f, q)
      apb(0, 12'h004, 0); `CHK("unmapped err", 1'b1, e) `CHK("unmapped data", 32'h0, q)
      apb(1, 12'h004, 0); apb(0, 12'h000, 0); `CHK("dropped write", 32'h8f, q)
      apb(1, 12'h000, 32'h03); $display("register test done");
   endtask
   task automatic t_lock();
      int p;
      pll_tracking_i <= 1'b1;
      p = 0;
      // Software polls the flag before it trusts the derived clock
      do begin apb(0, 12'h000, 0); p++; end while (q[6] !== 1'b1 && p < 20);
      `CHK("lock set", 1'b1, q[6])
      `CHK("lock latency", 1'b1, p < 6)
      pll_tracking_i <= 1'b0; wt(8); apb(0, 12'h000, 0);
      `CHK("lock clr", 1'b0, q[6])
      $display("lock test done");
   endtask
   task automatic t_osc();
      apb(1, 12'h000, 32'h83); power_down_i <= 1'b1; wt(4);
      `CHK("osc halted", 1'b0, osc_enable_o)
      `CHK("tic halted", 1'b0, tic_run_o)
      power_down_i <= 1'b0; apb(1, 12'h000, 32'h03); power_down_i <= 1'b1; wt(4);
      `CHK("osc kept", 1'b1, osc_enable_o)
      `CHK("tic kept", 1'b1, tic_run_o)
      power_down_i <= 1'b0; $display("oscillator test done");
   endtask
   task automatic t_div();
      for (int c = 0; c < 8; c++) begin
         apb(1, 12'h000, c); gap2(); `CHK("div gap", 1 << c, g)
         `CHK("div code", c[2:0], core_div_cur_o)
      end
      apb(1, 12'h000, 32'h0b); irq_in_service_i <= 1'b1; gap2(); `CHK("fast", 1, g)
      irq_in_service_i <= 1'b0; gap2(); `CHK("revert", 8, g)
      apb(1, 12'h000, 32'h03); irq_in_service_i <= 1'b1; gap2(); `CHK("no fast", 8, g)
      irq_in_service_i <= 1'b0; $display("divider test done");
   endtask
   task automatic t_pin();
      external_access_pin_i <= 1'b1; wt(10); apb(0, 12'h000, 0);
      `CHK("pin held", 1'b0, q[4])
      rst_i <= 1'b1; wt(3); rst_i <= 1'b0; wt(10); apb(0, 12'h000, 0);
      `CHK("pin caught", 1'b1, q[4])
      external_access_pin_i <= 1'b0; wt(10); apb(0, 12'h000, 0);
      `CHK("pin latched", 1'b1, q[4])
      $display("pin test done");
   endtask
   initial begin mclk_i = 1'b0; forever #5 mclk_i = ~mclk_i; end
   initial begin
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      {external_access_pin_i, pll_tracking_i, power_down_i, irq_in_service_i} = '0;
      // Non-blocking so the design's reset processes see the rising edge
      errors = 0; tests_run = 0; rst_i <= 1'b1;
      wt(3); rst_i <= 1'b0;
      t_reg(); t_lock(); t_osc(); t_div(); t_pin();
      report_and_stop();
   end
endmodule

// ===== verilog/pcc_core_div.sv
// Core clock divider producing a glitch-free one-cycle enable pulse
`timescale 1ns/1ps
module pcc_core_div
   import pcc_pkg::*;
#(
   parameter int CNT_W = PCC_DIV_CNT_W
) (
   // Clock and reset
   input  wire logic                 mclk_i,
   input  wire logic                 rst_i,
   // Requested division code
   input  wire logic [PCC_DIV_W-1:0] div_req_i,
   // Core clock enable and the code in force
   output logic                      core_clk_en_o,
   output logic [PCC_DIV_W-1:0]      div_cur_o
);
   logic [CNT_W-1:0]     cnt_r;
   logic [PCC_DIV_W-1:0] cur_r;
   logic                 en_r;
   logic [CNT_W-1:0]     last;
   logic                 wrap;

   // Period of 2**code cycles of the full-rate clock
   assign last = CNT_W'((1 << cur_r) - 1);
   assign wrap = (cnt_r == last);

   // A new code is taken only at the end of a whole period, so no
   // core cycle is ever cut short or stretched beyond either rate
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         cur_r <= PCC_DIV_DEFAULT;
      end else if (wrap) begin
         cnt_r <= '0;
         cur_r <= div_req_i;
      end else begin
         cnt_r <= CNT_W'(cnt_r + 1'b1);
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         en_r <= 1'b0;
      end else begin
         en_r <= wrap;
      end
   end

   assign core_clk_en_o = en_r;
   assign div_cur_o     = cur_r;
endmodule

// ===== verilog/pcc_pkg.sv
// Package: constants for the core clock control block
package pcc_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] PCC_CTRL_OFS    = 12'h000;
   localparam logic [7:0]  PCC_CTRL_RST    = 8'h03;
   localparam int          PCC_OSC_HALT_B  = 7;
   localparam int          PCC_LOCK_B      = 6;
   localparam int          PCC_RSVD_B      = 5;
   localparam int          PCC_EXT_PIN_B   = 4;
   localparam int          PCC_FAST_IRQ_B  = 3;
   localparam int          PCC_DIV_HI_B    = 2;
   localparam int          PCC_DIV_LO_B    = 0;
   localparam int          PCC_DIV_W       = 3;
   localparam logic [2:0]  PCC_DIV_FULL    = 3'h0;
   localparam logic [2:0]  PCC_DIV_DEFAULT = 3'h3;

   // ------------------------------------------------------------
   // Clocking
   // ------------------------------------------------------------
   localparam int          PCC_XTAL_HZ     = 32768;
   localparam int          PCC_PLL_MULT    = 384;
   localparam int          PCC_PLL_HZ      = PCC_XTAL_HZ * PCC_PLL_MULT;
   localparam int          PCC_DIV_CNT_W   = 7;
   // Cycles after reset release before the synchronised pin level is valid
   localparam logic [1:0]  PCC_PIN_SETTLE  = 2'h3;
endpackage

// ===== verilog/pcc_top.sv
// Top: PLL and core clock control register with APB access
//
// Operation
// - Halt bit set stops oscillator in power-down; clear keeps it running.
// - Running oscillator keeps the interval counter advancing in power-down.
// - Lock flag sets by itself when PLL tracks the crystal.
// - Lock flag clears by itself whenever PLL is not tracking.
// - Pin status bit reads external-access pin level caught at reset; read-only.
// - Fast response bit set: interrupts serviced at full core rate.
// - On interrupt return the core rate reverts to the divider code.
// - Fast response bit clear: interrupts run at the divided rate.
// - Three-bit code divides PLL clock by two to the code.
// - Default divider code is 011, PLL clock over eight.
// - PLL runs at 384 times the crystal, base of all divisions.
// - Control register holds 03 hex after power-on.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pcc_top
   import pcc_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Pins and analog status
   input  wire logic        external_access_pin_i,
   input  wire logic        pll_tracking_i,
   // Core side
   input  wire logic        power_down_i,
   input  wire logic        irq_in_service_i,
   // Clock outputs
   output logic             osc_enable_o,
   output logic             tic_run_o,
   output logic             core_clk_en_o,
   output logic [2:0]       core_div_cur_o
);
   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   logic                 osc_halt_in_sleep_r;
   logic                 fast_irq_response_r;
   logic [PCC_DIV_W-1:0] core_div_sel_r;
   logic                 pll_lock_r;
   logic                 ext_access_pin_state_r;
   logic                 osc_run_r;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   logic                 hit;
   logic                 wr_en;
   logic [7:0]           ctrl_rd;

   // Zero wait states; an unmapped address answers with an error
   assign hit   = (paddr_i == PCC_CTRL_OFS);
   assign wr_en = psel_i & penable_i & pwrite_i & hit;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         osc_halt_in_sleep_r <= PCC_CTRL_RST[PCC_OSC_HALT_B];
         fast_irq_response_r <= PCC_CTRL_RST[PCC_FAST_IRQ_B];
         core_div_sel_r      <= PCC_CTRL_RST[PCC_DIV_HI_B:PCC_DIV_LO_B];
      end else if (wr_en) begin
         // Status bits and the reserved bit ignore writes
         osc_halt_in_sleep_r <= pwdata_i[PCC_OSC_HALT_B];
         fast_irq_response_r <= pwdata_i[PCC_FAST_IRQ_B];
         core_div_sel_r      <= pwdata_i[PCC_DIV_HI_B:PCC_DIV_LO_B];
      end
   end

   // Lock bit comes from live status and pin bit from the level caught after reset; power-on value of lock
   // reads 0 until tracking is seen, which is why the reset value is 03
   always_comb begin
      ctrl_rd                                   = '0;
      ctrl_rd[PCC_OSC_HALT_B]                   = osc_halt_in_sleep_r;
      ctrl_rd[PCC_LOCK_B]                       = pll_lock_r;
      ctrl_rd[PCC_RSVD_B]                       = 1'b0;
      ctrl_rd[PCC_EXT_PIN_B]                    = ext_access_pin_state_r;
      ctrl_rd[PCC_FAST_IRQ_B]                   = fast_irq_response_r;
      ctrl_rd[PCC_DIV_HI_B:PCC_DIV_LO_B]        = core_div_sel_r;
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o <= '0;
      end else if (psel_i & ~penable_i & ~pwrite_i) begin
         prdata_o <= hit ? {24'h000000, ctrl_rd} : 32'h00000000;
      end
   end

   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] lock_sync_r;
   logic [2:0] pin_sync_r;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_sync_r <= '0;
         pin_sync_r  <= '0;
      end else begin
         lock_sync_r <= {lock_sync_r[1:0], pll_tracking_i};
         pin_sync_r  <= {pin_sync_r[1:0], external_access_pin_i};
      end
   end

   // Flag follows tracking in both directions, without software action
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pll_lock_r <= 1'b0;
      end else if (lock_sync_r[2] == lock_sync_r[1]) begin
         pll_lock_r <= lock_sync_r[2];
      end
   end

   // ------------------------------------------------------------
   // Pin capture after reset release
   // ------------------------------------------------------------
   // An async reset may not load a port value, so the level is caught
   // once the synchroniser has filled after release
   logic [1:0] settle_r;
   logic       captured_r;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         settle_r <= '0;
      end else if (settle_r != PCC_PIN_SETTLE) begin
         settle_r <= 2'(settle_r + 1'b1);
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         captured_r             <= 1'b0;
         ext_access_pin_state_r <= 1'b0;
      end else if (!captured_r && settle_r == PCC_PIN_SETTLE &&
                   pin_sync_r[2] == pin_sync_r[1]) begin
         captured_r             <= 1'b1;
         ext_access_pin_state_r <= pin_sync_r[2];
      end
   end

   // ------------------------------------------------------------
   // Oscillator and interval counter enable
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         osc_run_r <= 1'b1;
      end else begin
         osc_run_r <= ~(power_down_i & osc_halt_in_sleep_r);
      end
   end

   assign osc_enable_o = osc_run_r;
   // Interval counter is crystal clocked, so it runs whenever the crystal does
   assign tic_run_o    = osc_run_r;

   // ------------------------------------------------------------
   // Core clock selection
   // ------------------------------------------------------------
   logic [PCC_DIV_W-1:0] div_req;

   // Override holds only while an interrupt is in service; leaving it
   // returns to the programmed code, and with the bit clear there is none
   assign div_req = (fast_irq_response_r & irq_in_service_i) ?
                    PCC_DIV_FULL : core_div_sel_r;

   // Full rate is the 384x PLL clock, taken here as mclk_i
   pcc_core_div #(
      .CNT_W         (PCC_DIV_CNT_W)
   ) u_div (
      .mclk_i        (mclk_i),
      .rst_i         (rst_i),
      .div_req_i     (div_req),
      .core_clk_en_o (core_clk_en_o),
      .div_cur_o     (core_div_cur_o)
   );
endmodule
